// ### shared/fcl_pkg.sv
// constants and carrier types shared by the flash controller files
package fcl_pkg;
  // array geometry
  localparam int NUM_PAGES = 512;
  localparam int PAGE_BYTES = 256;
  localparam int NUM_WORDS = 32768;
  localparam int PAGE_WORDS = PAGE_BYTES / 4;
  localparam int WADDR_W = 15;
  localparam int BADDR_W = 17;
  localparam int PAGE_W = 9;
  localparam int NUM_LOCKS = 8;
  localparam int LOCK_PAGES = 64;
  localparam int NUM_GP = 2;
  localparam int CALIB_W = 8;
  // clock and operation times
  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int PROG_TIME_MS = 4;
  localparam int PAGE_ERASE_TIME_MS = 4;
  localparam int FULL_ERASE_TIME_MS = 10;
  localparam int NVM_BIT_TIME_US = 100;
  localparam int PROG_TIME_US = PROG_TIME_MS * US_PER_MS;
  localparam int PAGE_ERASE_TIME_US = PAGE_ERASE_TIME_MS * US_PER_MS;
  localparam int FULL_ERASE_TIME_US = FULL_ERASE_TIME_MS * US_PER_MS;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  // register offsets
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // register fields
  localparam int MODE_FWS_LSB = 0;
  localparam int MODE_DONE_IE = 8;
  localparam int MODE_ERR_IE = 9;
  localparam int TIMING_LSB = 0;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_DONE = 0;
  localparam int ST_LOCK_ERR = 1;
  localparam int ST_CMD_ERR = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_SECURE = 4;
  localparam int ST_LOCK_LSB = 8;
  localparam int ST_GP_LSB = 16;
  localparam int ST_CAL_LSB = 24;
  // reset values
  localparam logic [1:0] FWS_RST = 2'h0;
  localparam logic [7:0] TIMING_RST = 8'(CYC_PER_US);
  // command codes
  localparam logic [3:0] CMD_PROG = 4'h1;
  localparam logic [3:0] CMD_PAGE_ERASE = 4'h2;
  localparam logic [3:0] CMD_FULL_ERASE = 4'h3;
  localparam logic [3:0] CMD_SET_LOCK = 4'h4;
  localparam logic [3:0] CMD_CLR_LOCK = 4'h5;
  localparam logic [3:0] CMD_SET_SECURE = 4'h6;
  localparam logic [3:0] CMD_SET_GP = 4'h7;
  localparam logic [3:0] CMD_CLR_GP = 4'h8;

  typedef struct packed {
    logic [3:0] code;
    logic [9:0] arg;
  } fcl_cmd_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [16:0] addr;
    logic [31:0] wdata;
  } fcl_mst_s;
endpackage : fcl_pkg

// ### hdl/fcl_prefetch.sv
// dual word prefetch buffer in front of the flash read port
`timescale 1ns/1ps
module fcl_prefetch #(
  parameter int AW = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // read request from a bus master
  input wire logic req_i,
  input wire logic [AW-1:0] addr_i,
  output logic ready_o,
  output logic [31:0] rdata_o,
  // control
  input wire logic hold_i,
  input wire logic flush_i,
  input wire logic [1:0] fws_i,
  // array read port, one cycle latency
  output logic [AW-1:0] arr_addr_o,
  input wire logic [31:0] arr_data_i
);
  typedef enum logic [1:0] {PF_IDLE, PF_DEMAND, PF_AHEAD} fcl_pf_state_e;

  fcl_pf_state_e state;
  logic [AW-1:0] tag [2];
  logic [31:0] slot_data [2];
  logic [1:0] vld;
  logic [AW-1:0] fetch_addr;
  logic [2:0] wcnt;
  logic rdy;
  logic slot;
  logic hit;
  logic capture;

  if (AW < 2) begin : g_chk
    $error("fcl_prefetch: AW must be at least 2");
  end

  // even words live in slot 0, odd words in slot 1
  assign slot = addr_i[0];
  assign hit = vld[slot] && (tag[slot] == addr_i);
  // the extra cycle lets the registered array output settle on the address
  assign capture = (state != PF_IDLE) && (wcnt == ({1'b0, fws_i} + 3'h1));
  assign arr_addr_o = fetch_addr;
  assign ready_o = rdy;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PF_IDLE;
      fetch_addr <= '0;
      wcnt <= 3'h0;
    end else begin
      case (state)
        PF_IDLE: begin
          if (req_i && !hit && !hold_i && !rdy) begin
            fetch_addr <= addr_i;
            wcnt <= 3'h0;
            state <= PF_DEMAND;
          end
        end
        PF_DEMAND: begin
          wcnt <= wcnt + 3'h1;
          if (capture) begin
            // fetch ahead the following word into the other slot
            fetch_addr <= fetch_addr + 1'b1;
            wcnt <= 3'h0;
            state <= PF_AHEAD;
          end
        end
        PF_AHEAD: begin
          wcnt <= wcnt + 3'h1;
          if (capture) begin
            state <= PF_IDLE;
          end
        end
        default: state <= PF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld <= 2'h0;
      tag[0] <= '0;
      tag[1] <= '0;
      slot_data[0] <= 32'h0;
      slot_data[1] <= 32'h0;
    end else if (flush_i) begin
      vld <= 2'h0;
    end else if (capture) begin
      tag[fetch_addr[0]] <= fetch_addr;
      slot_data[fetch_addr[0]] <= arr_data_i;
      vld[fetch_addr[0]] <= 1'b1;
    end
  end

  // hits answer with no flash wait state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      rdy <= req_i && hit && !rdy;
      rdata_o <= slot_data[slot];
    end
  end
endmodule : fcl_prefetch

// ### hdl/fcl_flash_ctrl.sv
// flash controller: array, write buffer, command sequencer, nvm bits
//
// Notes on behaviour
// - array is 512 pages of 256 bytes, read as 32768 words.
// - a 256-byte page write buffer is filled by masters 32 bits wide.
// - software sets read wait states and the microsecond timebase.
// - commands: full erase, page erase, page program, nvm bit set/clear.
// - status shows done and errors; interrupt enables for each.
// - dual word prefetch serves consecutive halfword reads without waits.
// - eight lock bits, each guarding 64 pages of 16 Kbytes.
// - erase or program into a locked region aborts and raises interrupt.
// - set-lock protects the addressed region, clear-lock unprotects it.
// - the erase pin clears all eight lock bits.
// - security set blocks debug and fast port flash access.
// - security only set by command; cleared by erase pin then full erase.
// - two retained general bits with set and clear commands.
// - general bit 0 enables the brownout detector; erase pin clears it.
// - general bit 1 enables brownout reset; erase pin clears it.
// - eight calibration bits are read only and erase pin proof.
// - fast port may issue the same commands as the apb port.
// - fast programming mode when test pin and gpio lines 0,1 are high.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module fcl_flash_ctrl #(
  parameter int unsigned PROG_TIME_US = fcl_pkg::PROG_TIME_US,
  parameter int unsigned PAGE_ERASE_TIME_US = fcl_pkg::PAGE_ERASE_TIME_US,
  parameter int unsigned FULL_ERASE_TIME_US = fcl_pkg::FULL_ERASE_TIME_US,
  parameter int unsigned NVM_TIME_US = fcl_pkg::NVM_BIT_TIME_US,
  // factory calibration, value arbitrary
  parameter logic [7:0] CALIB_VALUE = 8'h00
) (
  // clock and resets
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic NVM_RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // system bus master port
  input wire fcl_pkg::fcl_mst_s MST_REQ_I,
  output logic MST_READY_O,
  output logic [31:0] MST_RDATA_O,
  // pins
  input wire logic ERASE_PIN_I,
  input wire logic TEST_MODE_PIN_I,
  input wire logic GPIO_LINE_ZERO_I,
  input wire logic GPIO_LINE_ONE_I,
  // fast programming port
  input wire logic FP_CMD_VALID_I,
  input wire fcl_pkg::fcl_cmd_s FP_CMD_I,
  output logic FP_CMD_READY_O,
  output logic FAST_PROG_MODE_O,
  output logic FP_ACCESS_OK_O,
  // debug emulator access
  input wire logic DBG_REQ_I,
  output logic DBG_GRANT_O,
  // status and control outputs
  output logic IRQ_O,
  output logic SECURITY_O,
  output logic BROWNOUT_DETECTOR_EN_O,
  output logic BROWNOUT_RESET_EN_O
);
  if (PROG_TIME_US == 0 || PROG_TIME_US > 65535 ||
      PAGE_ERASE_TIME_US == 0 || PAGE_ERASE_TIME_US > 65535 ||
      FULL_ERASE_TIME_US == 0 || FULL_ERASE_TIME_US > 65535 ||
      NVM_TIME_US == 0 || NVM_TIME_US > 65535) begin : g_chk
    $error("fcl_flash_ctrl: operation times must be 1..65535 us");
  end

  logic [31:0] flash_mem [fcl_pkg::NUM_WORDS];
  logic [31:0] wbuf [fcl_pkg::PAGE_WORDS];
  logic [31:0] arr_rdata;
  logic [14:0] arr_addr;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic erase_pin;
  logic fast_mode;
  logic [1:0] fws;
  logic done_ie;
  logic err_ie;
  logic [7:0] timing;
  logic [7:0] us_cnt;
  logic us_tick;
  logic done;
  logic lock_err;
  logic cmd_err;
  logic busy;
  fcl_pkg::fcl_cmd_s run_cmd;
  logic [15:0] timer;
  logic [14:0] walk_idx;
  logic [15:0] walk_left;
  logic finish;
  logic [7:0] lock;
  logic [1:0] gp;
  logic sec;
  logic erase_seen;
  logic apb_access;
  logic apb_cmd_wr;
  logic fp_ok;
  logic fp_go;
  logic cmd_go;
  fcl_pkg::fcl_cmd_s cmd_in;
  logic [2:0] region;
  logic bad_cmd;
  logic lock_viol;
  logic [15:0] next_timer;
  logic [14:0] next_idx;
  logic [15:0] next_left;
  logic [2:0] run_region;
  logic [31:0] status;
  logic [31:0] next_rdata;
  logic mapped;
  logic pf_ready;
  logic [31:0] pf_rdata;

  // pin synchronisers
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {GPIO_LINE_ONE_I, GPIO_LINE_ZERO_I, TEST_MODE_PIN_I,
                ERASE_PIN_I};
      sync2 <= sync1;
    end
  end

  assign erase_pin = sync2[0];
  assign fast_mode = &sync2[3:1];
  assign FAST_PROG_MODE_O = fast_mode;
  assign fp_ok = fast_mode && !sec;
  assign FP_ACCESS_OK_O = fp_ok;
  assign DBG_GRANT_O = DBG_REQ_I && !sec;

  assign apb_access = PSEL_I && PENABLE_I;
  assign apb_cmd_wr = apb_access && PWRITE_I && (PADDR_I == fcl_pkg::OFS_CMD);
  // apb wins a tie; the fast port simply sees ready low for that cycle
  assign FP_CMD_READY_O = fp_ok && !busy && !apb_cmd_wr;
  assign fp_go = FP_CMD_VALID_I && FP_CMD_READY_O;
  assign cmd_go = (apb_cmd_wr || fp_go) && !busy;
  assign cmd_in = apb_cmd_wr ?
    fcl_pkg::fcl_cmd_s'({PWDATA_I[fcl_pkg::CMD_CODE_LSB +: 4],
                         PWDATA_I[fcl_pkg::CMD_ARG_LSB +: 10]}) :
    FP_CMD_I;
  assign region = cmd_in.arg[8:6];
  assign run_region = run_cmd.arg[8:6];

  // command decode and lock check
  always_comb begin
    bad_cmd = 1'b0;
    lock_viol = 1'b0;
    next_timer = 16'(NVM_TIME_US);
    next_idx = {cmd_in.arg[8:0], 6'h00};
    next_left = 16'h0000;
    case (cmd_in.code)
      fcl_pkg::CMD_PROG: begin
        lock_viol = lock[region];
        next_timer = 16'(PROG_TIME_US);
        next_left = 16'(fcl_pkg::PAGE_WORDS);
      end
      fcl_pkg::CMD_PAGE_ERASE: begin
        lock_viol = lock[region];
        next_timer = 16'(PAGE_ERASE_TIME_US);
        next_left = 16'(fcl_pkg::PAGE_WORDS);
      end
      fcl_pkg::CMD_FULL_ERASE: begin
        lock_viol = |lock;
        next_timer = 16'(FULL_ERASE_TIME_US);
        next_idx = 15'h0000;
        next_left = 16'(fcl_pkg::NUM_WORDS);
      end
      fcl_pkg::CMD_SET_LOCK, fcl_pkg::CMD_CLR_LOCK,
      fcl_pkg::CMD_SET_SECURE: begin
      end
      fcl_pkg::CMD_SET_GP, fcl_pkg::CMD_CLR_GP: begin
        bad_cmd = cmd_in.arg[9:1] != 9'h000;
      end
      default: bad_cmd = 1'b1;
    endcase
  end

  // microsecond timebase from the programmable divider
  assign us_tick = ({1'b0, us_cnt} + 9'h001) >= {1'b0, timing};
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      us_cnt <= 8'h00;
    end else if (us_tick) begin
      us_cnt <= 8'h00;
    end else begin
      us_cnt <= us_cnt + 8'h01;
    end
  end

  // apb configuration registers
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fws <= fcl_pkg::FWS_RST;
      done_ie <= 1'b0;
      err_ie <= 1'b0;
      timing <= fcl_pkg::TIMING_RST;
    end else if (apb_access && PWRITE_I) begin
      if (PADDR_I == fcl_pkg::OFS_MODE) begin
        fws <= PWDATA_I[fcl_pkg::MODE_FWS_LSB +: 2];
        done_ie <= PWDATA_I[fcl_pkg::MODE_DONE_IE];
        err_ie <= PWDATA_I[fcl_pkg::MODE_ERR_IE];
      end
      if (PADDR_I == fcl_pkg::OFS_TIMING) begin
        timing <= PWDATA_I[fcl_pkg::TIMING_LSB +: 8];
      end
    end
  end

  // sequencer: walks the array one word per cycle while the time counts down; done when both end
  assign finish = busy && (timer == 16'h0000) && (walk_left == 16'h0000);
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      busy <= 1'b0;
      run_cmd <= '0;
      timer <= 16'h0000;
      walk_idx <= 15'h0000;
      walk_left <= 16'h0000;
    end else if (cmd_go && !bad_cmd && !lock_viol) begin
      busy <= 1'b1;
      run_cmd <= cmd_in;
      timer <= next_timer;
      walk_idx <= next_idx;
      walk_left <= next_left;
    end else if (busy) begin
      if (walk_left != 16'h0000) begin
        walk_idx <= walk_idx + 15'h0001;
        walk_left <= walk_left - 16'h0001;
      end
      if (us_tick && timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
      if (finish) begin
        busy <= 1'b0;
      end
    end
  end

  // array write side; erase leaves words all ones
  always_ff @(posedge CORE_CLK_I) begin
    if (busy && walk_left != 16'h0000) begin
      if (run_cmd.code == fcl_pkg::CMD_PROG) begin
        flash_mem[walk_idx] <= wbuf[walk_idx[5:0]];
      end else begin
        flash_mem[walk_idx] <= fcl_pkg::ERASED_WORD;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    arr_rdata <= flash_mem[arr_addr];
  end

  // masters fill the write buffer by word within the page
  always_ff @(posedge CORE_CLK_I) begin
    if (MST_REQ_I.valid && MST_REQ_I.write) begin
      wbuf[MST_REQ_I.addr[7:2]] <= MST_REQ_I.wdata;
    end
  end

  // command status flags; a new error set beats a read clear
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      done <= 1'b0;
      lock_err <= 1'b0;
      cmd_err <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      if (apb_access && !PWRITE_I && PADDR_I == fcl_pkg::OFS_STATUS) begin
        lock_err <= 1'b0;
        cmd_err <= 1'b0;
      end
      if (cmd_go) begin
        done <= bad_cmd || lock_viol;
        if (lock_viol) begin
          lock_err <= 1'b1;
        end
        if (bad_cmd) begin
          cmd_err <= 1'b1;
        end
      end
      if (finish) begin
        done <= 1'b1;
      end
      IRQ_O <= (done && done_ie) || ((lock_err || cmd_err) && err_ie);
    end
  end

  // retained bits survive the core reset, only power-on clears them
  always_ff @(posedge CORE_CLK_I or posedge NVM_RST_I) begin
    if (NVM_RST_I) begin
      lock <= 8'h00;
      gp <= 2'h0;
      sec <= 1'b0;
      erase_seen <= 1'b0;
    end else begin
      if (finish) begin
        case (run_cmd.code)
          fcl_pkg::CMD_SET_LOCK: lock[run_region] <= 1'b1;
          fcl_pkg::CMD_CLR_LOCK: lock[run_region] <= 1'b0;
          fcl_pkg::CMD_SET_SECURE: sec <= 1'b1;
          fcl_pkg::CMD_SET_GP: gp[run_cmd.arg[0]] <= 1'b1;
          fcl_pkg::CMD_CLR_GP: gp[run_cmd.arg[0]] <= 1'b0;
          fcl_pkg::CMD_FULL_ERASE: begin
            if (erase_seen) begin
              sec <= 1'b0;
              erase_seen <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // the pin outranks any command landing in the same cycle
      if (erase_pin) begin
        lock <= 8'h00;
        gp <= 2'h0;
        erase_seen <= 1'b1;
      end
    end
  end

  assign SECURITY_O = sec;
  assign BROWNOUT_DETECTOR_EN_O = gp[0];
  assign BROWNOUT_RESET_EN_O = gp[1];

  fcl_prefetch #(
    .AW(fcl_pkg::WADDR_W)
  ) u_prefetch (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .req_i(MST_REQ_I.valid && !MST_REQ_I.write),
    .addr_i(MST_REQ_I.addr[16:2]),
    .ready_o(pf_ready),
    .rdata_o(pf_rdata),
    .hold_i(busy),
    .flush_i(finish),
    .fws_i(fws),
    .arr_addr_o(arr_addr),
    .arr_data_i(arr_rdata)
  );

  assign MST_READY_O = MST_REQ_I.valid && (MST_REQ_I.write || pf_ready);
  assign MST_RDATA_O = pf_rdata;

  // apb read data is captured in the setup cycle so it leaves a flop
  always_comb begin
    status = 32'h0;
    status[fcl_pkg::ST_DONE] = done;
    status[fcl_pkg::ST_LOCK_ERR] = lock_err;
    status[fcl_pkg::ST_CMD_ERR] = cmd_err;
    status[fcl_pkg::ST_BUSY] = busy;
    status[fcl_pkg::ST_SECURE] = sec;
    status[fcl_pkg::ST_LOCK_LSB +: 8] = lock;
    status[fcl_pkg::ST_GP_LSB +: 2] = gp;
    status[fcl_pkg::ST_CAL_LSB +: 8] = CALIB_VALUE;
    next_rdata = 32'h0;
    mapped = 1'b1;
    case (PADDR_I)
      fcl_pkg::OFS_MODE: begin
        next_rdata[fcl_pkg::MODE_FWS_LSB +: 2] = fws;
        next_rdata[fcl_pkg::MODE_DONE_IE] = done_ie;
        next_rdata[fcl_pkg::MODE_ERR_IE] = err_ie;
      end
      fcl_pkg::OFS_TIMING: next_rdata[fcl_pkg::TIMING_LSB +: 8] = timing;
      fcl_pkg::OFS_CMD: next_rdata = 32'h0;
      fcl_pkg::OFS_STATUS: next_rdata = status;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I) begin
      PRDATA_O <= next_rdata;
    end
  end

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_access && !mapped;
endmodule : fcl_flash_ctrl

// ### tb/fcl_checker_assertions.sv
// concurrent checks on the flash controller ports
`timescale 1ns/1ps
module fcl_checker (
  // clock and resets
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic NVM_RST_I,
  // register bus
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // system bus master
  input wire fcl_pkg::fcl_mst_s MST_REQ_I,
  input wire logic MST_READY_O,
  // pins and grants
  input wire logic ERASE_PIN_I,
  input wire logic TEST_MODE_PIN_I,
  input wire logic GPIO_LINE_ZERO_I,
  input wire logic GPIO_LINE_ONE_I,
  input wire logic FAST_PROG_MODE_O,
  input wire logic FP_ACCESS_OK_O,
  input wire logic DBG_REQ_I,
  input wire logic DBG_GRANT_O,
  input wire logic SECURITY_O,
  input wire logic BROWNOUT_DETECTOR_EN_O,
  input wire logic BROWNOUT_RESET_EN_O
);
  logic mapped;
  logic erase_seen;
  // only the four word offsets 0x00..0x0c decode
  assign mapped = (PADDR_I[7:4] == 4'h0) && (PADDR_I[1:0] == 2'h0);
  always_ff @(posedge CORE_CLK_I or posedge NVM_RST_I) begin
    if (NVM_RST_I)
      erase_seen <= 1'b0;
    else if (ERASE_PIN_I)
      erase_seen <= 1'b1;
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  apb_ready_a: assert property (
    PSEL_I && PENABLE_I |-> PREADY_O) else $error("access without ready");
  bad_addr_a: assert property (
    PSEL_I && PENABLE_I && !mapped |->
    PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0))
    else $error("unmapped access not refused");
  good_addr_a: assert property (
    PSEL_I && PENABLE_I && mapped |-> !PSLVERR_O)
    else $error("mapped access refused");
  dbg_block_a: assert property (
    DBG_REQ_I |-> DBG_GRANT_O == !SECURITY_O)
    else $error("debug grant ignores security");
  fp_block_a: assert property (
    FP_ACCESS_OK_O == (FAST_PROG_MODE_O && !SECURITY_O))
    else $error("fast port access ignores security");
  fast_entry_a: assert property (
    (TEST_MODE_PIN_I && GPIO_LINE_ZERO_I && GPIO_LINE_ONE_I) [*3] |->
    FAST_PROG_MODE_O) else $error("fast mode not entered");
  fast_exit_a: assert property (
    (!TEST_MODE_PIN_I) [*3] |-> !FAST_PROG_MODE_O)
    else $error("fast mode without test pin");
  erase_clear_a: assert property (
    ERASE_PIN_I [*3] |=> !BROWNOUT_DETECTOR_EN_O && !BROWNOUT_RESET_EN_O)
    else $error("erase pin left brownout bits set");
  sec_clear_a: assert property (
    $fell(SECURITY_O) |-> erase_seen)
    else $error("security cleared without erase pin");
  wr_ready_a: assert property (
    MST_REQ_I.valid && MST_REQ_I.write |-> MST_READY_O)
    else $error("buffer write not accepted at once");
  rd_pulse_a: assert property (
    MST_READY_O && !MST_REQ_I.write |=> !(MST_READY_O && !MST_REQ_I.write))
    else $error("read ready repeated");
endmodule : fcl_checker

// ### tb/fcl_bus_master.sv
// system bus master model for flash reads and write buffer fills
`timescale 1ns/1ps
module fcl_bus_master (
  // clock
  input wire logic clk_i,
  // master port
  output fcl_pkg::fcl_mst_s req_o,
  input wire logic ready_i,
  input wire logic [31:0] rdata_i
);
  initial req_o = '0;
  // one word access; ok is low when no answer came
  task automatic xfer(input logic w, input logic [16:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk_i);
    req_o <= '{1'b1, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ready_i && n < 200);
    q = rdata_i;
    ok = ready_i;
    // released lines go inverted so a stale value never looks valid
    req_o <= '{1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : fcl_bus_master

// ### tb/flash_ctrl_lock_nvm_bits_test.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
module flash_ctrl_lock_nvm_bits_test;
  typedef struct {
    logic [3:0] c;
    logic [9:0] a;
    logic [17:0] e;
  } fcl_row_s;
  // command, argument, expected status bits 17:0 once finished
  fcl_row_s rows[10] = '{
    '{fcl_pkg::CMD_SET_GP, 10'h0, 18'h10001},
    '{fcl_pkg::CMD_SET_GP, 10'h1, 18'h30001},
    '{fcl_pkg::CMD_CLR_GP, 10'h1, 18'h10001},
    '{fcl_pkg::CMD_SET_GP, 10'h2, 18'h10005},
    '{4'hf, 10'h0, 18'h10005},
    '{fcl_pkg::CMD_SET_LOCK, 10'h040, 18'h10201},
    '{fcl_pkg::CMD_PAGE_ERASE, 10'h046, 18'h10203},
    '{fcl_pkg::CMD_PROG, 10'h07f, 18'h10203},
    '{fcl_pkg::CMD_FULL_ERASE, 10'h0, 18'h10203},
    '{fcl_pkg::CMD_CLR_LOCK, 10'h064, 18'h10001}};
  logic clk = 0, rst = 1, nvm_rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, ok;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, d, mst_rdata;
  logic mst_ready, erase = 0, tst = 0, g0 = 0, g1 = 0, irq, sec;
  logic fp_valid = 0, fp_ready, fpm, fp_ok, dbg_req = 0, dbg_gnt;
  logic bod_en, bor_en;
  fcl_pkg::fcl_mst_s mst_req;
  fcl_pkg::fcl_cmd_s fp_cmd = '0;
  int errors = 0, num_checks = 0, n;
  always #25 clk = ~clk;
  // short operation times keep the run small
  fcl_flash_ctrl #(.PROG_TIME_US(2), .PAGE_ERASE_TIME_US(2),
    .FULL_ERASE_TIME_US(2), .NVM_TIME_US(2), .CALIB_VALUE(8'h5a)) dut_u (
    .CORE_CLK_I(clk), .RST_I(rst), .NVM_RST_I(nvm_rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MST_REQ_I(mst_req),
    .MST_READY_O(mst_ready), .MST_RDATA_O(mst_rdata),
    .ERASE_PIN_I(erase), .TEST_MODE_PIN_I(tst), .GPIO_LINE_ZERO_I(g0),
    .GPIO_LINE_ONE_I(g1), .FP_CMD_VALID_I(fp_valid), .FP_CMD_I(fp_cmd),
    .FP_CMD_READY_O(fp_ready), .FAST_PROG_MODE_O(fpm),
    .FP_ACCESS_OK_O(fp_ok), .DBG_REQ_I(dbg_req), .DBG_GRANT_O(dbg_gnt),
    .IRQ_O(irq), .SECURITY_O(sec), .BROWNOUT_DETECTOR_EN_O(bod_en),
    .BROWNOUT_RESET_EN_O(bor_en));
  fcl_bus_master mst_u (.clk_i(clk), .req_o(mst_req),
    .ready_i(mst_ready), .rdata_i(mst_rdata));
  task automatic stop_test();
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] x,
    input logic [31:0] y);
    num_checks++;
    if (x !== y) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!pready && k < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // polls status until idle; error bits seen on the way are kept
  task automatic wait_done();
    logic [1:0] acc;
    int k;
    acc = 2'h0;
    k = 0;
    do begin
      apb(0, fcl_pkg::OFS_STATUS, 32'h0);
      acc = acc | q[2:1];
      k++;
    end while (!(q[0] === 1'b1 && q[3] === 1'b0) && k < 20000);
    q[2:1] = q[2:1] | acc;
    if (k >= 20000) begin
      chk("wait done", 32'h1, 32'h0);
      stop_test();
    end
  endtask : wait_done
  task automatic cmd(input logic [3:0] c, input logic [9:0] a);
    apb(1, fcl_pkg::OFS_CMD, {14'h0, a, 4'h0, c});
    wait_done();
  endtask : cmd
  // one master word access; a missing answer ends the run
  task automatic mst(input logic w, input logic [16:0] a,
    input logic [31:0] wd);
    mst_u.xfer(w, a, wd, d, ok);
    if (ok !== 1'b1) begin
      chk("mst ready", 32'h1, {31'h0, ok});
      stop_test();
    end
  endtask : mst
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    nvm_rst <= 0;
    apb(0, fcl_pkg::OFS_MODE, 32'h0);
    chk("mode", {30'h0, fcl_pkg::FWS_RST}, q);
    apb(0, fcl_pkg::OFS_TIMING, 32'h0);
    chk("timing", {24'h0, fcl_pkg::TIMING_RST}, q);
    apb(0, fcl_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h5a000000, q);
    apb(1, fcl_pkg::OFS_TIMING, 32'h1);
    apb(1, fcl_pkg::OFS_MODE, 32'h303);
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].a);
      chk("cmd", 32'(rows[i].e), 32'(q[17:0]));
    end
    chk("irq", 32'h1, {31'h0, irq});
    chk("bod", 32'h1, {31'h0, bod_en});
    tst <= 1;
    g0 <= 1;
    g1 <= 1;
    repeat (4) @(posedge clk);
    chk("fast mode", 32'h1, {31'h0, fpm});
    fp_cmd <= '{fcl_pkg::CMD_SET_GP, 10'h1};
    fp_valid <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!fp_ready && n < 50);
    chk("fp ready", 32'h1, {31'h0, fp_ready});
    if (fp_ready !== 1'b1) stop_test();
    fp_valid <= 0;
    wait_done();
    chk("fast port gp", 32'h30001, {14'h0, q[17:0]});
    chk("bor", 32'h1, {31'h0, bor_en});
    for (int i = 0; i < 64; i++)
      mst(1, 17'(768 + 4 * i), 32'ha5a50000 + i);
    apb(1, fcl_pkg::OFS_CMD, {14'h0, 10'h3, 4'h0, fcl_pkg::CMD_PROG});
    apb(1, fcl_pkg::OFS_CMD, {14'h0, 10'h1, 4'h0, fcl_pkg::CMD_CLR_GP});
    wait_done();
    chk("cmd while busy", 32'h30001, {14'h0, q[17:0]});
    for (int i = 0; i < 64; i++) begin
      mst(0, 17'(768 + 4 * i), 32'h0);
      chk("read back", 32'ha5a50000 + i, d);
    end
    cmd(fcl_pkg::CMD_PAGE_ERASE, 10'h3);
    mst(0, 17'd768, 32'h0);
    chk("page erase", fcl_pkg::ERASED_WORD, d);
    cmd(fcl_pkg::CMD_SET_LOCK, 10'h0);
    cmd(fcl_pkg::CMD_SET_SECURE, 10'h0);
    chk("security", 32'h1, {31'h0, sec});
    dbg_req <= 1;
    @(posedge clk);
    chk("dbg closed", 32'h0, {31'h0, dbg_gnt});
    chk("fast closed", 32'h0, {31'h0, fp_ok});
    erase <= 1;
    repeat (4) @(posedge clk);
    erase <= 0;
    repeat (3) @(posedge clk);
    apb(0, fcl_pkg::OFS_STATUS, 32'h0);
    chk("erase pin", 32'h5a000011, q);
    cmd(fcl_pkg::CMD_FULL_ERASE, 10'h0);
    chk("full erase", 32'h5a000001, q);
    chk("security off", 32'h0, {31'h0, sec});
    chk("dbg open", 32'h1, {31'h0, dbg_gnt});
    mst(0, 17'd768, 32'h0);
    chk("erased", fcl_pkg::ERASED_WORD, d);
    apb(0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, q);
    tst <= 0;
    repeat (4) @(posedge clk);
    chk("fast off", 32'h0, {31'h0, fpm});
    stop_test();
  end
endmodule : flash_ctrl_lock_nvm_bits_test
bind fcl_flash_ctrl fcl_checker chk_u (.*);
